// ---- core/prms_pkg.sv ----
`default_nettype none
package prms_pkg;
	localparam int unsigned prms_num_refs = 3;
	localparam int unsigned prms_aw = 12;
	// printed offsets are not all multiples of four: they are indices, byte address = 4*index
	localparam logic [7:0] prms_idx_mode = 8'h1f;
	localparam logic [7:0] prms_idx_refsel = 8'h20;
	localparam logic [7:0] prms_idx_fmask = 8'h21;
	localparam logic [7:0] prms_idx_wtr = 8'h22;
	localparam logic [7:0] prms_idx_rev = 8'h23;
	localparam logic [7:0] prms_idx_ctrl = 8'h1e;
	localparam logic [7:0] prms_idx_rank0 = 8'h24;
	localparam logic [7:0] prms_idx_rank1 = 8'h25;
	localparam logic [7:0] prms_idx_status = 8'h28;
	localparam logic [7:0] prms_idx_steer = 8'h30;

	localparam logic [7:0] prms_rst_refsel = 8'h00;
	localparam logic [7:0] prms_rst_fmask = 8'h3c;
	localparam logic [7:0] prms_rst_wtr = 8'h00;
	localparam logic [7:0] prms_rst_rev = 8'h00;
	localparam logic [7:0] prms_rst_ctrl = 8'h00;
	localparam logic [7:0] prms_rst_rank0 = 8'h10;
	localparam logic [7:0] prms_rst_rank1 = 8'h02;
	localparam logic [7:0] prms_rst_steer = 8'h00;

	localparam logic [2:0] prms_mode_man_normal = 3'h0;
	localparam logic [2:0] prms_mode_man_hold = 3'h1;
	localparam logic [2:0] prms_mode_man_free = 3'h2;
	localparam logic [2:0] prms_mode_auto = 3'h3;
	localparam logic [2:0] prms_mode_steer = 3'h4;
	// strap low selects this mode after reset, strap high the other
	localparam logic [2:0] prms_strap_lo_mode = 3'h2;
	localparam logic [2:0] prms_strap_hi_mode = 3'h3;

	localparam logic [3:0] prms_rank_off = 4'hf;
	localparam logic [1:0] prms_ref_none = 2'h3;

	localparam int unsigned prms_clk_hz = 40000000;
	localparam int unsigned prms_minute_s = 60;
	localparam longint unsigned prms_minute_cycles = longint'(prms_clk_hz) * prms_minute_s;

	typedef enum logic [1:0] {
		prms_st_free_type = 2'b00,
		prms_st_locked_type = 2'b01,
		prms_st_hold_type = 2'b11,
		prms_st_steer_type = 2'b10
	} prms_state_type;
endpackage : prms_pkg
`default_nettype wire

// ---- core/prms_mode_select.sv ----
`default_nettype none
module prms_mode_select #(
	parameter longint unsigned minute_cycles = prms_pkg::prms_minute_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [prms_pkg::prms_aw-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_strap,
	input wire logic [3:0] fail_flags_0,
	input wire logic [3:0] fail_flags_1,
	input wire logic [3:0] fail_flags_2,
	output logic [1:0] active_ref,
	output logic ref_valid,
	output logic holdover,
	output logic free_run,
	output logic oscillator_steer,
	output logic [7:0] steer_word
);
	import prms_pkg::*;

	localparam int unsigned nr = prms_num_refs;

	logic [2:0] mode_q;
	logic strap_done_q;
	logic [3:0] refsel_q;
	logic [7:0] fmask_q, wtr_q, rev_q, ctrl_q, rank0_q, rank1_q, steer_q;
	logic [1:0] cur_q;
	prms_state_type state_q;
	logic [nr-1:0] avail_q;
	logic [63:0] tick_cnt_q;
	// one spare bit so a code of 15 can still be exceeded
	logic [4:0] minutes_q [nr];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	logic [3:0] fl [nr];
	logic [3:0] rank [nr];
	logic [nr-1:0] sw_fail, hold_fail;
	logic minute_tick;
	logic [1:0] best;
	logic best_ok;
	logic [7:0] idx;
	logic wr, rd, hit;

	assign fl[0] = fail_flags_0;
	assign fl[1] = fail_flags_1;
	assign fl[2] = fail_flags_2;
	assign rank[0] = rank0_q[3:0];
	assign rank[1] = rank0_q[7:4];
	assign rank[2] = rank1_q[3:0];

	function automatic logic addr_ok(input logic [prms_aw-1:0] a);
		return a[1:0] == 2'h0 && a[prms_aw-1:10] == '0;
	endfunction : addr_ok

	function automatic logic is_reg(input logic [7:0] i);
		return i == prms_idx_mode || i == prms_idx_refsel || i == prms_idx_fmask
			|| i == prms_idx_wtr || i == prms_idx_rev || i == prms_idx_ctrl
			|| i == prms_idx_rank0 || i == prms_idx_rank1 || i == prms_idx_status
			|| i == prms_idx_steer;
	endfunction : is_reg

	// a reference is qualified when not disabled by rank, not failing for switching and available again after its restore wait
	function automatic logic usable(input int unsigned r, input logic [nr-1:0] sf,
			input logic [nr-1:0] av, input logic [3:0] rk);
		return rk != prms_rank_off && !sf[r] && av[r];
	endfunction : usable

	always_comb begin
		logic [3:0] brank;
		brank = prms_rank_off;
		best = prms_ref_none;
		best_ok = 1'b0;
		for (int unsigned r = 0; r < nr; r++) begin
			sw_fail[r] = |(fl[r] & fmask_q[3:0]);
			hold_fail[r] = |(fl[r] & fmask_q[7:4]);
		end
		for (int unsigned r = 0; r < nr; r++) begin
			if (usable(r, sw_fail, avail_q, rank[r]) && (!best_ok || rank[r] < brank)) begin
				best = 2'(r);
				brank = rank[r];
				best_ok = 1'b1;
			end
		end
	end

	assign idx = paddr[9:2];
	assign hit = addr_ok(paddr) && is_reg(idx);
	assign wr = psel && penable && pwrite && pready_q;
	assign rd = psel && !penable && !pwrite;
	assign minute_tick = tick_cnt_q == 64'(minute_cycles - 1);

	// zero-wait-state apb: pready is raised in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= psel && !penable && !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (rd && hit) begin
			unique case (idx)
				prms_idx_mode: prdata_q <= {29'h0, mode_q};
				prms_idx_refsel: prdata_q <= {28'h0, refsel_q};
				prms_idx_fmask: prdata_q <= {24'h0, fmask_q};
				prms_idx_wtr: prdata_q <= {28'h0, wtr_q[3:0]};
				prms_idx_rev: prdata_q <= {29'h0, rev_q[2:0]};
				prms_idx_ctrl: prdata_q <= {31'h0, ctrl_q[0]};
				prms_idx_rank0: prdata_q <= {24'h0, rank0_q};
				prms_idx_rank1: prdata_q <= {28'h0, rank1_q[3:0]};
				prms_idx_status: prdata_q <= {27'h0, avail_q, state_q == prms_st_hold_type,
					state_q == prms_st_locked_type};
				default: prdata_q <= {24'h0, steer_q};
			endcase
		end else if (rd) begin
			prdata_q <= 32'h0;
		end
	end

	// strap caught by a clocked process after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_q <= 1'b0;
			mode_q <= prms_strap_lo_mode;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			mode_q <= mode_strap ? prms_strap_hi_mode : prms_strap_lo_mode;
		end else if (wr && hit && idx == prms_idx_mode) begin
			mode_q <= pwdata[2:0]; // upper bits ignored
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refsel_q <= prms_rst_refsel[3:0];
		end else if (mode_q == prms_mode_auto) begin
			refsel_q <= {2'h0, cur_q};
		end else if (wr && hit && idx == prms_idx_refsel && mode_q == prms_mode_man_normal) begin
			refsel_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmask_q <= prms_rst_fmask;
			wtr_q <= prms_rst_wtr;
			rev_q <= prms_rst_rev;
			ctrl_q <= prms_rst_ctrl;
			rank0_q <= prms_rst_rank0;
			rank1_q <= prms_rst_rank1;
			steer_q <= prms_rst_steer;
		end else if (wr && hit) begin
			unique case (idx)
				prms_idx_fmask: fmask_q <= pwdata[7:0];
				prms_idx_wtr: wtr_q <= {4'h0, pwdata[3:0]};
				prms_idx_rev: rev_q <= {5'h0, pwdata[2:0]};
				prms_idx_ctrl: ctrl_q <= {7'h0, pwdata[0]};
				prms_idx_rank0: rank0_q <= pwdata[7:0];
				prms_idx_rank1: rank1_q <= {4'h0, pwdata[3:0]};
				prms_idx_steer: steer_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 64'h0;
		end else begin
			tick_cnt_q <= minute_tick ? 64'h0 : tick_cnt_q + 64'h1;
		end
	end

	// restore timer: counts ticks of the free-running minute counter after the failure clears, so granularity is one minute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			avail_q <= '1;
			for (int unsigned r = 0; r < nr; r++) minutes_q[r] <= 5'h0;
		end else begin
			for (int unsigned r = 0; r < nr; r++) begin
				if (sw_fail[r]) begin
					avail_q[r] <= 1'b0;
					minutes_q[r] <= 5'h0;
				end else if (!avail_q[r]) begin
					// the tick runs free, so code+1 ticks guarantee at least code whole minutes
					if (wtr_q[3:0] == 4'h0 || minutes_q[r] > {1'b0, wtr_q[3:0]}) begin
						avail_q[r] <= 1'b1;
					end else if (minute_tick) begin
						minutes_q[r] <= minutes_q[r] + 5'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= prms_st_free_type;
			cur_q <= prms_ref_none;
		end else begin
			unique case (mode_q)
				prms_mode_man_normal: begin
					if (refsel_q[3:2] != 2'h0 || refsel_q[1:0] == prms_ref_none) begin
						state_q <= prms_st_hold_type; // reserved code
					end else if (hold_fail[refsel_q[1:0]]) begin
						state_q <= prms_st_hold_type;
					end else begin
						state_q <= prms_st_locked_type;
						cur_q <= refsel_q[1:0];
					end
				end
				prms_mode_man_hold: state_q <= prms_st_hold_type;
				prms_mode_man_free: begin
					state_q <= prms_st_free_type;
					cur_q <= prms_ref_none;
				end
				prms_mode_auto: begin
					if (state_q == prms_st_locked_type && cur_q != prms_ref_none
							&& !sw_fail[cur_q] && rank[cur_q] != prms_rank_off
							&& !(ctrl_q[0] && rev_q[best] && best_ok && best != cur_q)) begin
						state_q <= prms_st_locked_type; // non-revertive keeps
					end else if (best_ok) begin
						state_q <= prms_st_locked_type;
						cur_q <= best;
					end else if (cur_q != prms_ref_none && !hold_fail[cur_q]
							&& state_q == prms_st_locked_type) begin
						state_q <= prms_st_locked_type;
					end else begin
						state_q <= prms_st_hold_type;
					end
				end
				prms_mode_steer: begin
					state_q <= prms_st_steer_type;
					cur_q <= prms_ref_none;
				end
				default: begin
					state_q <= prms_st_free_type;
					cur_q <= prms_ref_none;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_ref <= prms_ref_none;
			ref_valid <= 1'b0;
			holdover <= 1'b0;
			free_run <= 1'b1;
			oscillator_steer <= 1'b0;
			steer_word <= 8'h0;
		end else begin
			active_ref <= cur_q;
			ref_valid <= state_q == prms_st_locked_type;
			holdover <= state_q == prms_st_hold_type;
			free_run <= state_q == prms_st_free_type;
			oscillator_steer <= state_q == prms_st_steer_type;
			steer_word <= steer_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule : prms_mode_select
`default_nettype wire

// ---- verification/prms_mode_select_checker.sv ----
`default_nettype none
module prms_mode_select_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] active_ref,
	input wire logic ref_valid,
	input wire logic holdover,
	input wire logic free_run,
	input wire logic oscillator_steer
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	property p_answer; s_setup |=> s_access; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_ready_own; pready |-> psel && penable; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_misalign; s_setup and (paddr[1:0] != 2'h0) |=> pslverr; endproperty
	property p_onehot; $onehot({ref_valid, holdover, free_run, oscillator_steer}); endproperty
	property p_code; ref_valid |-> active_ref <= 2'h2; endproperty
	property p_noref; free_run || oscillator_steer |-> active_ref == 2'h3; endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_ready_own: assert property (p_ready_own) else $error("ready outside access");
	a_err: assert property (p_err) else $error("error without ready");
	a_misalign: assert property (p_misalign) else $error("misaligned not refused");
	a_onehot: assert property (p_onehot) else $error("state outputs not one-hot");
	a_code: assert property (p_code) else $error("reserved reference code");
	a_noref: assert property (p_noref) else $error("reference shown while unlocked");
endmodule : prms_mode_select_checker
bind prms_mode_select prms_mode_select_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.active_ref(active_ref), .ref_valid(ref_valid), .holdover(holdover), .free_run(free_run),
	.oscillator_steer(oscillator_steer));
`default_nettype wire

// ---- verification/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import prms_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mode_strap, err;
	logic ref_valid, holdover, free_run, oscillator_steer;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] ff0, ff1, ff2;
	logic [1:0] lsb;
	logic [1:0] active_ref;
	logic [7:0] steer_word;
	int failures, tests_run;
	// one minute shortened to 20 cycles so restore delays fit the run
	prms_mode_select #(.minute_cycles(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_strap(mode_strap), .fail_flags_0(ff0),
		.fail_flags_1(ff1), .fail_flags_2(ff2), .active_ref(active_ref), .ref_valid(ref_valid),
		.holdover(holdover), .free_run(free_run), .oscillator_steer(oscillator_steer),
		.steer_word(steer_word));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("mismatches %0d comparisons %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, lsb};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rc(input string w, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(w, rd, exp);
	endtask : rc
	// state word: reference (3 when unlocked), locked, holdover, free-run, steered
	task automatic wt(input string w, input logic [5:0] exp, input int n);
		logic [5:0] s;
		repeat (n) begin
			s = {ref_valid ? active_ref : 2'h3, ref_valid, holdover, free_run, oscillator_steer};
			if (s === exp) break;
			@(posedge pclk);
		end
		chk(w, {ref_valid ? active_ref : 2'h3, ref_valid, holdover, free_run, oscillator_steer}, exp);
	endtask : wt
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ff0, ff1, ff2} = '0;
		lsb = 2'h0;
		mode_strap = 1'b1;
		failures = 0;
		tests_run = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rc("mode", prms_idx_mode, 32'h3);
		rc("refsel", prms_idx_refsel, 32'h0);
		rc("fmask", prms_idx_fmask, 32'h3c);
		rc("restore", prms_idx_wtr, 32'h0);
		rc("revert", prms_idx_rev, 32'h0);
		rc("ctrl", prms_idx_ctrl, 32'h0);
		rc("rank0", prms_idx_rank0, 32'h10);
		wt("auto best", 6'h08, 10);
		apb(1'b1, prms_idx_refsel, 32'h2);
		rc("refsel ro", prms_idx_refsel, 32'h0);
		ff0 <= 4'h1;
		repeat (6) @(posedge pclk);
		wt("masked fail", 6'h08, 1);
		ff0 <= 4'h4;
		wt("switch", 6'h18, 10);
		apb(1'b1, prms_idx_ctrl, 32'h1);
		apb(1'b1, prms_idx_rev, 32'h1);
		apb(1'b1, prms_idx_wtr, 32'h1);
		ff0 <= 4'h0;
		repeat (10) @(posedge pclk);
		wt("restore wait", 6'h18, 1);
		wt("revert", 6'h08, 40);
		apb(1'b1, prms_idx_ctrl, 32'h0);
		ff0 <= 4'h4;
		wt("switch 2", 6'h18, 10);
		ff0 <= 4'h0;
		repeat (60) @(posedge pclk);
		wt("no revert", 6'h18, 1);
		apb(1'b1, prms_idx_fmask, 32'h0c);
		{ff0, ff1, ff2} <= {3{4'h6}};
		repeat (6) @(posedge pclk);
		wt("hold masked", 6'h18, 1);
		apb(1'b1, prms_idx_fmask, 32'h3c);
		wt("auto hold", 6'h34, 10);
		{ff0, ff1, ff2} <= '0;
		apb(1'b1, prms_idx_mode, 32'h0);
		apb(1'b1, prms_idx_refsel, 32'h2);
		wt("manual", 6'h28, 10);
		ff2 <= 4'h1;
		wt("manual hold", 6'h34, 10);
		ff2 <= 4'h0;
		apb(1'b1, prms_idx_refsel, 32'h3);
		wt("reserved ref", 6'h34, 10);
		apb(1'b1, prms_idx_mode, 32'h1);
		wt("mode 1", 6'h34, 10);
		apb(1'b1, prms_idx_mode, 32'h2);
		wt("mode 2", 6'h32, 10);
		apb(1'b1, prms_idx_mode, 32'h4);
		apb(1'b1, prms_idx_steer, 32'h5a);
		wt("mode 4", 6'h31, 10);
		repeat (2) @(posedge pclk);
		chk("steer", {24'h0, steer_word}, 32'h5a);
		apb(1'b0, 8'hff, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		lsb = 2'h1;
		apb(1'b0, prms_idx_mode, 32'h0);
		lsb = 2'h0;
		chk("misaligned", {err, rd[30:0]}, 32'h80000000);
		results();
	end
endmodule : tb_top
`default_nettype wire
